// ==== hdl/host_pin_mux.sv ====
module host_pin_mux (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Control register load.
  input wire logic ctlWr,
  input wire logic [hpin_pkg::CTL_W-1:0] ctlData,
  input wire logic dirWr,
  input wire logic [hpin_pkg::PIN_N-1:0] dirData,
  input wire logic [hpin_pkg::PIN_N-1:0] gpOutData,
  // Requests from the transfer logic, active high.
  input wire logic txReq,
  input wire logic rxReq,
  // Shared pins.
  input wire logic [hpin_pkg::PIN_N-1:0] pinIn,
  output logic [hpin_pkg::PIN_N-1:0] pinOut,
  output logic [hpin_pkg::PIN_N-1:0] pinOe,
  // Decoded host signals, active high.
  output logic dataStrobe,
  output logic writeStrobe,
  output logic readStrobe,
  output logic rwSelect,
  output logic portSelect,
  output logic addrTen,
  output logic addrLatch,
  output logic requestAck,
  // Status readback.
  output logic [hpin_pkg::CTL_W-1:0] ctlRead,
  output logic [hpin_pkg::PIN_N-1:0] dirRead,
  output logic [hpin_pkg::PIN_N-1:0] gpInData
);
  import hpin_pkg::*;

  logic [CTL_W-1:0] host_port_control_reg_r;
  logic [CTL_W-1:0] host_port_control_reg_nxt;
  logic [PIN_N-1:0] gp_direction_reg_r;
  logic [PIN_N-1:0] gp_direction_reg_nxt;
  logic [PIN_N-1:0] pinOut_r;
  logic [PIN_N-1:0] pinOut_nxt;
  logic [PIN_N-1:0] pinOe_r;
  logic [PIN_N-1:0] pinOe_nxt;
  logic [PIN_N-1:0] gpIn_r;
  logic [PIN_N-1:0] gpIn_nxt;
  logic [7:0] hostIn_r;
  logic [7:0] hostIn_nxt;
  pin_mode_t mode [PIN_N];
  logic hostEn;
  logic gpioEn;
  logic muxBus;
  logic dualDs;
  logic dualReq;
  logic trqOut;
  logic trqOe;
  logic rrqOut;
  logic rrqOe;
  logic [PIN_N-1:0] gpOe;

  assign hostEn = host_port_control_reg_r[C_HOST];
  assign gpioEn = host_port_control_reg_r[C_GPIO];
  assign muxBus = host_port_control_reg_r[C_MUX];
  assign dualDs = host_port_control_reg_r[C_DUAL_DS];
  assign dualReq = host_port_control_reg_r[C_DUAL_REQ];

  req_cfg_if reqCfg ();
  assign reqCfg.reqPolHigh = host_port_control_reg_r[C_REQ_POL];
  assign reqCfg.openDrain = host_port_control_reg_r[C_OPEN_DRAIN];

  // Control and direction registers.
  always_comb begin
    host_port_control_reg_nxt = host_port_control_reg_r;
    gp_direction_reg_nxt = gp_direction_reg_r;
    if (ctlWr) begin
      host_port_control_reg_nxt = ctlData;
    end
    if (dirWr) begin
      gp_direction_reg_nxt = dirData;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      host_port_control_reg_r <= CTL_RESET;
      gp_direction_reg_r <= DIR_RESET;
    end else begin
      host_port_control_reg_r <= host_port_control_reg_nxt;
      gp_direction_reg_r <= gp_direction_reg_nxt;
    end
  end

  // Pin ownership; the host function takes precedence over GPIO.
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      always_comb begin
        if (hostEn) begin
          mode[gi] = MODE_HOST;
        end else if (gpioEn && (gi != P_TRQ || muxBus)) begin
          mode[gi] = MODE_GPIO;
        end else begin
          mode[gi] = MODE_OFF;
        end
        gpOe[gi] = (mode[gi] == MODE_GPIO) && gp_direction_reg_r[gi];
      end
    end
  endgenerate

  // Request pins share one driver shape; only enable and source differ.
  req_drive u_trq (
    .cfg(reqCfg),
    .req(dualReq ? txReq : (txReq | rxReq)),
    .enable(mode[P_TRQ] == MODE_HOST),
    .drvOut(trqOut),
    .drvOe(trqOe)
  );

  req_drive u_rrq (
    .cfg(reqCfg),
    .req(rxReq),
    .enable((mode[P_ACK] == MODE_HOST) && dualReq),
    .drvOut(rrqOut),
    .drvOe(rrqOe)
  );

  // Pin drive. Input-only host pins and idle pins are never driven.
  always_comb begin
    pinOut_nxt = gpOutData;
    pinOe_nxt = gpOe;
    if (mode[P_TRQ] == MODE_HOST) begin
      pinOut_nxt[P_TRQ] = trqOut;
      pinOe_nxt[P_TRQ] = trqOe;
    end
    if (mode[P_ACK] == MODE_HOST) begin
      pinOut_nxt[P_ACK] = rrqOut;
      pinOe_nxt[P_ACK] = rrqOe;
    end
    gpIn_nxt = pinIn;
  end

  // Reset clears every enable, so request pins float as inputs.
  always_ff @(posedge mclk) begin
    if (srst) begin
      pinOut_r <= PINS_ZERO;
      pinOe_r <= PINS_ZERO;
      gpIn_r <= PINS_ZERO;
    end else begin
      pinOut_r <= pinOut_nxt;
      pinOe_r <= pinOe_nxt;
      gpIn_r <= gpIn_nxt;
    end
  end

  // Decoded host inputs; a clear polarity bit inverts the pin.
  always_comb begin
    hostIn_nxt = 8'h00;
    if (hostEn) begin
      if (dualDs) begin
        hostIn_nxt[1] = pinIn[P_DS] ~^ host_port_control_reg_r[C_DS_POL];
        hostIn_nxt[2] = pinIn[P_RW] ~^ host_port_control_reg_r[C_DS_POL];
      end else begin
        hostIn_nxt[0] = pinIn[P_DS] ~^ host_port_control_reg_r[C_DS_POL];
        hostIn_nxt[3] = pinIn[P_RW];
      end
      if (muxBus) begin
        hostIn_nxt[5] = pinIn[P_CS];
        hostIn_nxt[6] = pinIn[P_ALS] ~^ host_port_control_reg_r[C_AS_POL];
      end else begin
        hostIn_nxt[4] = pinIn[P_CS] ~^ host_port_control_reg_r[C_CS_POL];
      end
      if (!dualReq) begin
        hostIn_nxt[7] = pinIn[P_ACK] ~^ host_port_control_reg_r[C_ACK_POL];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      hostIn_r <= 8'h00;
    end else begin
      hostIn_r <= hostIn_nxt;
    end
  end

  assign pinOut = pinOut_r;
  assign pinOe = pinOe_r;
  assign dataStrobe = hostIn_r[0];
  assign writeStrobe = hostIn_r[1];
  assign readStrobe = hostIn_r[2];
  assign rwSelect = hostIn_r[3];
  assign portSelect = hostIn_r[4];
  assign addrTen = hostIn_r[5];
  assign addrLatch = hostIn_r[6];
  assign requestAck = hostIn_r[7];
  assign ctlRead = host_port_control_reg_r;
  assign dirRead = gp_direction_reg_r;
  assign gpInData = gpIn_r;

  property p_resetFloat;
    @(posedge mclk) srst |=> (pinOe_r == PINS_ZERO);
  endproperty
  a_resetFloat: assert property (p_resetFloat)
    else $error("Pin driven right after reset.");

  property p_idleFloat;
    @(posedge mclk) disable iff (srst)
      (!hostEn && !gpioEn) |=> (pinOe_r == PINS_ZERO);
  endproperty
  a_idleFloat: assert property (p_idleFloat)
    else $error("Unassigned pin is driven.");

  property p_dataStrobe;
    @(posedge mclk) disable iff (srst)
      (hostEn && !dualDs) |=> (dataStrobe ==
        ($past(pinIn[P_DS]) ~^ $past(host_port_control_reg_r[C_DS_POL])));
  endproperty
  a_dataStrobe: assert property (p_dataStrobe)
    else $error("Data strobe decode wrong.");

  property p_writeStrobe;
    @(posedge mclk) disable iff (srst)
      (hostEn && dualDs && !host_port_control_reg_r[C_DS_POL]) |=>
        (writeStrobe == !$past(pinIn[P_DS])) && !dataStrobe;
  endproperty
  a_writeStrobe: assert property (p_writeStrobe)
    else $error("Write strobe decode wrong.");

  property p_select;
    @(posedge mclk) disable iff (srst)
      (hostEn && !muxBus) |=> (portSelect ==
        ($past(pinIn[P_CS]) ~^ $past(host_port_control_reg_r[C_CS_POL])))
        && !addrTen;
  endproperty
  a_select: assert property (p_select)
    else $error("Chip select decode wrong.");

  property p_addrTen;
    @(posedge mclk) disable iff (srst)
      (hostEn && muxBus) |=> (addrTen == $past(pinIn[P_CS])) && !portSelect;
  endproperty
  a_addrTen: assert property (p_addrTen)
    else $error("Address line ten decode wrong.");

  property p_bit14Gpio;
    @(posedge mclk) disable iff (srst)
      (!hostEn && !muxBus) |=> !pinOe_r[P_TRQ];
  endproperty
  a_bit14Gpio: assert property (p_bit14Gpio)
    else $error("Bit 14 driven outside multiplexed style.");

  property p_gpioDir;
    @(posedge mclk) disable iff (srst)
      (!hostEn && gpioEn) |=> (pinOe_r[P_DS] == $past(gp_direction_reg_r[P_DS]))
        && (pinOut_r[P_DS] == $past(gpOutData[P_DS]));
  endproperty
  a_gpioDir: assert property (p_gpioDir)
    else $error("GPIO direction not followed.");

  property p_combinedReq;
    @(posedge mclk) disable iff (srst)
      (hostEn && !dualReq && !reqCfg.openDrain && !reqCfg.reqPolHigh &&
        (txReq || rxReq)) |=> pinOe_r[P_TRQ] && !pinOut_r[P_TRQ];
  endproperty
  a_combinedReq: assert property (p_combinedReq)
    else $error("Combined request not asserted low.");

  property p_rxReq;
    @(posedge mclk) disable iff (srst)
      (hostEn && dualReq && !reqCfg.openDrain) |=> pinOe_r[P_ACK] &&
        (pinOut_r[P_ACK] == ($past(rxReq) ~^ $past(reqCfg.reqPolHigh)));
  endproperty
  a_rxReq: assert property (p_rxReq)
    else $error("Receive request level wrong.");

  property p_openDrain;
    @(posedge mclk) disable iff (srst)
      (hostEn && reqCfg.openDrain) |=> !pinOut_r[P_TRQ] && !pinOut_r[P_ACK];
  endproperty
  a_openDrain: assert property (p_openDrain)
    else $error("Open-drain request drove high.");

  property p_ack;
    @(posedge mclk) disable iff (srst)
      (hostEn && !dualReq && !host_port_control_reg_r[C_ACK_POL]) |=>
        (requestAck == !$past(pinIn[P_ACK])) && !pinOe_r[P_ACK];
  endproperty
  a_ack: assert property (p_ack)
    else $error("Acknowledge decode wrong.");

  c_hostReq: cover property (@(posedge mclk) disable iff (srst)
    hostEn && dualReq && txReq ##1 pinOe_r[P_TRQ]);
  c_gpioOut: cover property (@(posedge mclk) disable iff (srst)
    !hostEn && gpioEn && muxBus ##1 pinOe_r[P_TRQ]);
  c_latch: cover property (@(posedge mclk) disable iff (srst)
    hostEn && muxBus ##1 addrLatch);
endmodule : host_pin_mux

// ==== hdl/hpin_pkg.sv ====
package hpin_pkg;
  // Shared pin positions inside the pin vectors.
  localparam int PIN_N = 6;
  localparam int P_ALS = 0;
  localparam int P_RW = 1;
  localparam int P_DS = 2;
  localparam int P_CS = 3;
  localparam int P_TRQ = 4;
  localparam int P_ACK = 5;
  // Field positions of host_port_control_reg.
  localparam int CTL_W = 11;
  localparam int C_HOST = 0;
  localparam int C_GPIO = 1;
  localparam int C_MUX = 2;
  localparam int C_DUAL_DS = 3;
  localparam int C_DUAL_REQ = 4;
  localparam int C_OPEN_DRAIN = 5;
  localparam int C_DS_POL = 6;
  localparam int C_CS_POL = 7;
  localparam int C_REQ_POL = 8;
  localparam int C_ACK_POL = 9;
  localparam int C_AS_POL = 10;
  // Zero polarity bits mean active-low; zero selects mean pins idle.
  localparam logic [CTL_W-1:0] CTL_RESET = 11'h000;
  localparam logic [PIN_N-1:0] DIR_RESET = 6'h00;
  localparam logic [PIN_N-1:0] PINS_ZERO = 6'h00;
  typedef enum logic [1:0] {MODE_OFF, MODE_HOST, MODE_GPIO} pin_mode_t;
endpackage : hpin_pkg

// ==== hdl/req_cfg_if.sv ====
interface req_cfg_if;
  logic reqPolHigh;
  logic openDrain;
  modport ctl (output reqPolHigh, output openDrain);
  modport drv (input reqPolHigh, input openDrain);
endinterface : req_cfg_if

// ==== hdl/req_drive.sv ====
module req_drive (
  // Shared request configuration.
  req_cfg_if.drv cfg,
  // Request from the transfer logic, active high.
  input wire logic req,
  input wire logic enable,
  // Pin drive, before registering.
  output logic drvOut,
  output logic drvOe
);
  logic level;

  always_comb begin
    // Polarity is an inversion between internal request and pin level.
    level = cfg.reqPolHigh ? req : ~req;
    // Open drain only ever pulls low; a high level is left to the pull-up.
    if (cfg.openDrain) begin
      drvOut = 1'b0;
      drvOe = enable & ~level;
    end else begin
      drvOut = level;
      drvOe = enable;
    end
  end
endmodule : req_drive

// ==== tb/host_port_pin_function_control_bench.sv ====
module host_port_pin_function_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import hpin_pkg::*;
  typedef struct {int due; logic [42:0] exp; logic [42:0] msk;} note_t;
  localparam int CYC_MAX = 3000;
  localparam logic [10:0] CFGS [8] = '{11'h001, 11'h7fd, 11'h021,
    11'h115, 11'h002, 11'h006, 11'h003, 11'h000};
  logic mclk = 0, srst = 1, ctlWr = 0, dirWr = 0, txReq = 0, rxReq = 0;
  logic [CTL_W-1:0] ctlData = 11'h000;
  logic [PIN_N-1:0] dirData = 6'h00, gpOutData = 6'h00;
  logic [PIN_N-1:0] hostLvl = 6'h00, hostOe = 6'h3f;
  wire [CTL_W-1:0] ctlRead;
  wire [PIN_N-1:0] pinIn, pinOut, pinOe, dirRead, gpInData;
  wire [7:0] dec;
  wire [42:0] obsVec;
  note_t q[$];
  note_t n;
  int cyc = 0, bad_count = 0, num_checks = 0;

  always #12.5 mclk = ~mclk;

  host_pin_mux DUT (.mclk(mclk), .srst(srst), .ctlWr(ctlWr),
    .ctlData(ctlData), .dirWr(dirWr), .dirData(dirData),
    .gpOutData(gpOutData), .txReq(txReq), .rxReq(rxReq), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .dataStrobe(dec[7]),
    .writeStrobe(dec[6]), .readStrobe(dec[5]), .rwSelect(dec[4]),
    .portSelect(dec[3]), .addrTen(dec[2]), .addrLatch(dec[1]),
    .requestAck(dec[0]), .ctlRead(ctlRead), .dirRead(dirRead),
    .gpInData(gpInData));
  hpin_host_model host (.mclk(mclk), .hostLvl(hostLvl), .hostOe(hostOe),
    .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));
  assign obsVec = {ctlRead, dirRead, gpInData, pinOut, pinOe, dec};

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [42:0] seen, input logic [42:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // Returns {pinOut, pinOe, decodes} for pin levels p.
  function automatic logic [19:0] model(logic [10:0] c, logic [5:0] d,
      logic [5:0] p, logic tx, logic rx, logic [5:0] g);
    logic [5:0] o;
    logic [5:0] e;
    logic [7:0] r;
    logic req;
    logic lvl;
    o = g;
    e = 6'h00;
    r = 8'h00;
    if (c[C_HOST]) begin
      if (c[C_DUAL_DS]) begin
        r[6] = p[P_DS] ~^ c[C_DS_POL];
        r[5] = p[P_RW] ~^ c[C_DS_POL];
      end else begin
        r[7] = p[P_DS] ~^ c[C_DS_POL];
        r[4] = p[P_RW];
      end
      if (c[C_MUX]) begin
        r[2] = p[P_CS];
        r[1] = p[P_ALS] ~^ c[C_AS_POL];
      end else
        r[3] = p[P_CS] ~^ c[C_CS_POL];
      if (!c[C_DUAL_REQ])
        r[0] = p[P_ACK] ~^ c[C_ACK_POL];
      for (int i = P_TRQ; i <= P_ACK; i++) begin
        req = (i == P_ACK) ? rx : (c[C_DUAL_REQ] ? tx : tx | rx);
        lvl = c[C_REQ_POL] ? req : ~req;
        if (i == P_TRQ || c[C_DUAL_REQ]) begin
          o[i] = c[C_OPEN_DRAIN] ? 1'b0 : lvl;
          e[i] = c[C_OPEN_DRAIN] ? ~lvl : 1'b1;
        end
      end
    end else if (c[C_GPIO])
      e = d & (c[C_MUX] ? 6'h3f : 6'h2f);
    return {o, e, r};
  endfunction : model

  task automatic run_test(input logic [10:0] c, input logic [5:0] d);
    logic [5:0] ho;
    logic [19:0] m;
    logic [31:0] r;
    @(posedge mclk);
    ctlWr <= 1'b1;
    ctlData <= c;
    dirWr <= 1'b1;
    dirData <= d;
    @(posedge mclk);
    ctlWr <= 1'b0;
    dirWr <= 1'b0;
    m = model(c, d, 6'h00, 1'b0, 1'b0, 6'h00);
    ho = c[C_HOST] ? (c[C_DUAL_REQ] ? 6'h0f : 6'h2f) : ~m[13:8];
    // Hand pins over without a cycle where both sides drive.
    hostOe <= hostOe & ho;
    @(posedge mclk);
    hostOe <= ho;
    @(posedge mclk);
    for (int k = 0; k < 40; k++) begin
      @(posedge mclk);
      r = $urandom;
      hostLvl <= r[5:0];
      txReq <= r[6];
      rxReq <= r[7];
      gpOutData <= r[13:8];
      m = model(c, d, r[5:0], r[6], r[7], r[13:8]);
      q.push_back('{cyc + 2, {c, d, r[5:0] & ho, m},
        {17'h1ffff, ho, m[13:8], 14'h3fff}});
    end
    $display("test ctl=%h dir=%h done", c, d);
  endtask : run_test

  always @(posedge mclk) begin
    cyc <= cyc + 1;
  end

  always @(posedge mclk) begin
    #1;
    while (q.size() != 0 && q[0].due <= cyc) begin
      n = q.pop_front();
      check(obsVec & n.msk, n.exp & n.msk);
    end
    if (cyc >= CYC_MAX) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    void'($urandom(32'h5381));
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    foreach (CFGS[i])
      run_test(CFGS[i], 6'($urandom) | 6'h10);
    repeat (3)
      run_test({10'($urandom), 1'b1}, 6'($urandom));
    run_test(11'h7fd, 6'h3f);
    @(posedge mclk);
    srst <= 1'b1;
    q.push_back('{cyc + 2, 43'h0, {17'h1ffff, 6'h00, 20'hfffff}});
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    $display("test mid-run reset done");
    repeat (4) @(posedge mclk);
    final_report();
  end
endmodule : host_port_pin_function_control_bench

// ==== tb/hpin_host_model.sv ====
module hpin_host_model (
  // Clock.
  input wire logic mclk,
  // Host processor drive.
  input wire logic [hpin_pkg::PIN_N-1:0] hostLvl,
  input wire logic [hpin_pkg::PIN_N-1:0] hostOe,
  // Device drive.
  input wire logic [hpin_pkg::PIN_N-1:0] pinOut,
  input wire logic [hpin_pkg::PIN_N-1:0] pinOe,
  // Resolved pin levels.
  output logic [hpin_pkg::PIN_N-1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  import hpin_pkg::*;
  logic [PIN_N-1:0] last;
  always_ff @(posedge mclk) begin
    last <= pinIn;
  end
  // Released inputs below P_TRQ flip every cycle, so a stale level never passes; released request pins are pulled high.
  always_comb begin
    for (int i = 0; i < PIN_N; i++) begin
      if (pinOe[i] && hostOe[i])
        pinIn[i] = 1'bx;
      else if (pinOe[i])
        pinIn[i] = pinOut[i];
      else if (hostOe[i])
        pinIn[i] = hostLvl[i];
      else if (i >= P_TRQ)
        pinIn[i] = 1'b1;
      else
        pinIn[i] = ~last[i];
    end
  end
endmodule : hpin_host_model
